// ==== lcdp_ports.sv ====
`timescale 1ns/100ps
// Function
// (RQ1) First port has six pins, each direction set by its own bit
// (RQ2) An enabled peripheral forces first-port pin direction while it stays enabled
// (RQ3) Software avoids read-modify-write of first-port direction while peripherals run
// (RQ4) First-port data bits 7 and 6 always read zero
// (RQ5) Reset sets first-port direction to inputs; data kept over other resets
// (RQ6) Pin 0 timer-1 oscillator out or clock in; pin 1 oscillator in
// (RQ7) Pin 2 capture, compare or PWM; pin 3 serial clock
// (RQ8) Pin 4 SPI data in or I2C data; pin 5 serial data out
// (RQ9) Second port has eight pins; low five are I/O or segment drivers
// (RQ10) Second-port upper three pins are inputs or segment/common drivers
// (RQ11) Second-port direction governs pins 0 to 4 in port mode only
// (RQ12) Second-port pins map to segments 0-4, 29-31 or commons 3-1
// (RQ13) Power-on reset gives LCD-shared pins to the segment drivers
// (RQ14) Set segment-select bit gives pins to LCD, overriding direction
// (RQ15) Third port is eight input-only pins shared with segment drivers
// (RQ16) Third-port pins map to segments 5 to 11 and 27
// (RQ17) Three select bits govern third port; one also serves another port (here select bits 1, 2 and 6 serve the third port only)
// (RQ18) Second and third data reset zero; their directions and select ones
// (RQ19) Data register reads return pin levels; writes load the latch
// (RQ20) Direction one makes pin input; zero drives the latch
// (RQ21) Input-only port never drives its pins whatever is written
module lcdp_ports #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic warm_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lcdp_pkg::lcdp_periph_t periph,
  input wire logic [3:0] com_used,
  input wire logic [5:0] first_pin_in,
  output lcdp_pkg::lcdp_first_drive_t first_pin_drive,
  output logic [5:0] first_pin_level,
  input wire logic [7:0] second_pin_in,
  output lcdp_pkg::lcdp_second_drive_t second_pin_drive,
  output logic [7:0] second_pin_level,
  input wire logic [7:0] third_pin_in,
  output logic [7:0] third_pin_level,
  output logic [7:0] lcd_segment_pin_select,
  output logic [31:0] seg_owned,
  output logic [3:0] com_owned
);
  import lcdp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (ADDR_WIDTH < IDX_W + 2 || ADDR_WIDTH > 32)
  begin : g_bad_addr
    $error("ADDR_WIDTH must be 11 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [ADDR_WIDTH-1:0] byte_addr(input logic [8:0] idx);
    byte_addr = ADDR_WIDTH'({idx, 2'b00});
  endfunction

  function automatic lcdp_reg_t decode(input logic [ADDR_WIDTH-1:0] a);
    decode = LCDP_REG_NONE;
    if (a == byte_addr(IDX_FIRST_DATA))
    begin
      decode = LCDP_REG_FIRST_DATA;
    end
    else if (a == byte_addr(IDX_SECOND_DATA))
    begin
      decode = LCDP_REG_SECOND_DATA;
    end
    else if (a == byte_addr(IDX_THIRD_DATA))
    begin
      decode = LCDP_REG_THIRD_DATA;
    end
    else if (a == byte_addr(IDX_FIRST_DIR))
    begin
      decode = LCDP_REG_FIRST_DIR;
    end
    else if (a == byte_addr(IDX_SECOND_DIR))
    begin
      decode = LCDP_REG_SECOND_DIR;
    end
    else if (a == byte_addr(IDX_THIRD_DIR))
    begin
      decode = LCDP_REG_THIRD_DIR;
    end
    else if (a == byte_addr(IDX_LCD_SEL))
    begin
      decode = LCDP_REG_LCD_SEL;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [21:0] pin_meta;
  logic [21:0] pin_sync;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {third_pin_in, second_pin_in, first_pin_in};
      pin_sync <= pin_meta;
    end
  end

  logic [5:0] first_sync;
  logic [7:0] second_sync;
  logic [7:0] third_sync;
  assign first_sync = pin_sync[5:0];
  assign second_sync = pin_sync[13:6];
  assign third_sync = pin_sync[21:14];

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [5:0] first_data;
  logic [5:0] first_dir;
  logic [7:0] second_data;
  logic [7:0] second_dir;
  logic [7:0] third_dir;
  logic [7:0] lcd_sel;
  logic [5:0] next_first_data;
  logic [5:0] next_first_dir;
  logic [7:0] next_second_data;
  logic [7:0] next_second_dir;
  logic [7:0] next_third_dir;
  logic [7:0] next_lcd_sel;
  logic wr_fire;
  lcdp_reg_t sel_reg;

  assign sel_reg = decode(paddr);
  assign wr_fire = psel & penable & pready & pwrite & pstrb[0];

  always_comb
  begin
    next_first_data = first_data;
    next_first_dir = first_dir;
    next_second_data = second_data;
    next_second_dir = second_dir;
    next_third_dir = third_dir;
    next_lcd_sel = lcd_sel;
    if (warm_reset)
    begin
      next_first_dir = RST_FIRST_DIR; // RQ5
      next_second_data = RST_SECOND_DATA; // RQ18
      next_second_dir = RST_SECOND_DIR; // RQ18
      next_third_dir = RST_THIRD_DIR; // RQ18
      next_lcd_sel = RST_LCD_SEL; // RQ18
    end
    else if (wr_fire)
    begin
      case (sel_reg)
        LCDP_REG_FIRST_DATA: next_first_data = pwdata[5:0]; // RQ19
        LCDP_REG_SECOND_DATA: next_second_data = pwdata[7:0]; // RQ19
        LCDP_REG_FIRST_DIR: next_first_dir = pwdata[5:0]; // RQ1
        LCDP_REG_SECOND_DIR: next_second_dir = pwdata[7:0];
        LCDP_REG_THIRD_DIR: next_third_dir = pwdata[7:0];
        LCDP_REG_LCD_SEL: next_lcd_sel = pwdata[7:0];
        LCDP_REG_THIRD_DATA: next_lcd_sel = lcd_sel; // RQ21
        default: next_lcd_sel = lcd_sel;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_data <= RST_FIRST_DATA;
      first_dir <= RST_FIRST_DIR; // RQ5
      second_data <= RST_SECOND_DATA; // RQ18
      second_dir <= RST_SECOND_DIR;
      third_dir <= RST_THIRD_DIR;
      lcd_sel <= RST_LCD_SEL; // RQ13
    end
    else
    begin
      first_data <= next_first_data;
      first_dir <= next_first_dir;
      second_data <= next_second_data;
      second_dir <= next_second_dir;
      third_dir <= next_third_dir;
      lcd_sel <= next_lcd_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, no wait states
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] rd_mux;
  logic setup;

  assign setup = psel & ~penable;

  always_comb
  begin
    rd_mux = '0;
    case (sel_reg)
      LCDP_REG_FIRST_DATA: rd_mux = {26'h0, first_sync}; // RQ4 RQ19
      LCDP_REG_SECOND_DATA: rd_mux = {24'h0, second_sync}; // RQ19
      LCDP_REG_THIRD_DATA: rd_mux = {24'h0, third_sync}; // RQ19
      LCDP_REG_FIRST_DIR: rd_mux = {26'h0, first_dir};
      LCDP_REG_SECOND_DIR: rd_mux = {24'h0, second_dir};
      LCDP_REG_THIRD_DIR: rd_mux = {24'h0, third_dir};
      LCDP_REG_LCD_SEL: rd_mux = {24'h0, lcd_sel};
      default: rd_mux = '0;
    endcase
    next_pready = setup;
    next_prdata = (setup && !pwrite) ? rd_mux : '0;
    next_pslverr = setup && (sel_reg == LCDP_REG_NONE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and LCD ownership
  lcdp_first_drive_t next_first_drive;
  lcdp_second_drive_t next_second_drive;
  logic [31:0] next_seg_owned;
  logic [3:0] next_com_owned;
  logic [7:0] third_lcd;
  logic second_low_lcd;
  logic second_high_lcd;

  always_comb
  begin
    second_low_lcd = lcd_sel[SEL_LOW_SECOND];
    second_high_lcd = lcd_sel[SEL_HIGH_SECOND];
    for (int i = 0; i < THIRD_PINS; i++)
    begin
      if (i <= THIRD_A_LAST)
      begin
        third_lcd[i] = lcd_sel[SEL_THIRD_A]; // RQ17
      end
      else if (i <= THIRD_B_LAST)
      begin
        third_lcd[i] = lcd_sel[SEL_THIRD_B]; // RQ17
      end
      else
      begin
        third_lcd[i] = lcd_sel[SEL_THIRD_TOP]; // RQ17
      end
    end
  end

  always_comb
  begin
    // First port: direction bit, then peripheral forcing
    next_first_drive.level = first_data;
    next_first_drive.oe = ~first_dir; // RQ1 RQ20
    if (periph.timer1_osc_en)
    begin
      next_first_drive.oe[PIN_T1_OUT] = 1'b0; // RQ2 RQ6
      next_first_drive.oe[PIN_T1_IN] = 1'b0; // RQ6
    end
    if (periph.ccp_en)
    begin
      next_first_drive.oe[PIN_CCP] = periph.ccp_drives; // RQ2 RQ7
      next_first_drive.level[PIN_CCP] = periph.ccp_out; // RQ7
    end
    if (periph.ssp_en && periph.ssp_i2c)
    begin
      next_first_drive.oe[PIN_SCK] = periph.sck_drive & ~periph.sck_out; // RQ7
      next_first_drive.level[PIN_SCK] = 1'b0;
      next_first_drive.oe[PIN_SDI] = periph.sda_drive_low; // RQ8
      next_first_drive.level[PIN_SDI] = 1'b0;
    end
    else if (periph.ssp_en)
    begin
      next_first_drive.oe[PIN_SCK] = periph.sck_drive; // RQ2 RQ7
      next_first_drive.level[PIN_SCK] = periph.sck_out;
      next_first_drive.oe[PIN_SDI] = 1'b0; // RQ8
      next_first_drive.oe[PIN_SDO] = 1'b1; // RQ8
      next_first_drive.level[PIN_SDO] = periph.sdo_out;
    end
  end

  always_comb
  begin
    // Second port: low five pins only, never while LCD owns them
    next_second_drive.level = second_data[SECOND_IO_PINS-1:0]; // RQ9
    next_second_drive.oe = second_low_lcd ? '0 : ~second_dir[SECOND_IO_PINS-1:0]; // RQ11 RQ14

    // Segment and common ownership
    next_seg_owned = '0;
    next_com_owned = '0;
    for (int i = 0; i < SECOND_IO_PINS; i++)
    begin
      next_seg_owned[SEG_SECOND_LOW_BASE + i] = second_low_lcd; // RQ12
    end
    for (int i = 0; i < THIRD_PINS - 1; i++)
    begin
      next_seg_owned[SEG_THIRD_BASE + i] = third_lcd[i]; // RQ16
    end
    next_seg_owned[SEG_THIRD_TOP] = third_lcd[THIRD_PINS-1]; // RQ16
    for (int j = 0; j < SECOND_PINS - SECOND_IO_PINS; j++)
    begin
      next_seg_owned[SEG_SECOND_HIGH_BASE + j] =
        second_high_lcd & ~com_used[COM_SECOND_PIN5 - j]; // RQ10 RQ12
      next_com_owned[COM_SECOND_PIN5 - j] =
        second_high_lcd & com_used[COM_SECOND_PIN5 - j]; // RQ10 RQ12
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_pin_drive <= '0;
    end
    else
    begin
      first_pin_drive <= next_first_drive;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      second_pin_drive <= '0;
      seg_owned <= '0;
      com_owned <= '0;
      lcd_segment_pin_select <= RST_LCD_SEL;
    end
    else
    begin
      second_pin_drive <= next_second_drive;
      seg_owned <= next_seg_owned;
      com_owned <= next_com_owned;
      lcd_segment_pin_select <= lcd_sel; // RQ14
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_pin_level <= '0;
      second_pin_level <= '0;
      third_pin_level <= '0;
    end
    else
    begin
      first_pin_level <= first_sync;
      second_pin_level <= second_sync; // RQ10
      third_pin_level <= third_sync; // RQ15 RQ21
    end
  end

endmodule

// ==== lcdp_pkg.sv ====
package lcdp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam int IDX_W = 9;
  localparam logic [8:0] IDX_FIRST_DATA = 9'h007;
  localparam logic [8:0] IDX_SECOND_DATA = 9'h008;
  localparam logic [8:0] IDX_THIRD_DATA = 9'h009;
  localparam logic [8:0] IDX_FIRST_DIR = 9'h087;
  localparam logic [8:0] IDX_SECOND_DIR = 9'h088;
  localparam logic [8:0] IDX_THIRD_DIR = 9'h089;
  localparam logic [8:0] IDX_LCD_SEL = 9'h10d;

  ////////////////////////////////////////////////////////////////////////////
  // Pin counts
  localparam int FIRST_PINS = 6;
  localparam int SECOND_PINS = 8;
  localparam int SECOND_IO_PINS = 5;
  localparam int THIRD_PINS = 8;
  localparam int REG_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [5:0] RST_FIRST_DATA = 6'h00;
  localparam logic [5:0] RST_FIRST_DIR = 6'h3f;
  localparam logic [7:0] RST_SECOND_DATA = 8'h00;
  localparam logic [7:0] RST_SECOND_DIR = 8'hff;
  localparam logic [7:0] RST_THIRD_DIR = 8'hff;
  localparam logic [7:0] RST_LCD_SEL = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Segment-select bit positions
  localparam int SEL_LOW_SECOND = 0;
  localparam int SEL_THIRD_A = 1;
  localparam int SEL_THIRD_B = 2;
  localparam int SEL_THIRD_TOP = 6;
  localparam int SEL_HIGH_SECOND = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Segment and common numbering
  localparam int SEGS = 32;
  localparam int COMS = 4;
  localparam int SEG_SECOND_LOW_BASE = 0;
  localparam int SEG_THIRD_BASE = 5;
  localparam int SEG_THIRD_TOP = 27;
  localparam int SEG_SECOND_HIGH_BASE = 29;
  localparam int COM_SECOND_PIN5 = 3;
  localparam int THIRD_A_LAST = 3;
  localparam int THIRD_B_LAST = 6;

  ////////////////////////////////////////////////////////////////////////////
  // First-port pin roles
  localparam int PIN_T1_OUT = 0;
  localparam int PIN_T1_IN = 1;
  localparam int PIN_CCP = 2;
  localparam int PIN_SCK = 3;
  localparam int PIN_SDI = 4;
  localparam int PIN_SDO = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    LCDP_REG_NONE,
    LCDP_REG_FIRST_DATA,
    LCDP_REG_SECOND_DATA,
    LCDP_REG_THIRD_DATA,
    LCDP_REG_FIRST_DIR,
    LCDP_REG_SECOND_DIR,
    LCDP_REG_THIRD_DIR,
    LCDP_REG_LCD_SEL
  } lcdp_reg_t;

  typedef struct packed {
    logic timer1_osc_en;
    logic ccp_en;
    logic ccp_drives;
    logic ccp_out;
    logic ssp_en;
    logic ssp_i2c;
    logic sck_drive;
    logic sck_out;
    logic sda_drive_low;
    logic sdo_out;
  } lcdp_periph_t;

  typedef struct packed {
    logic [5:0] level;
    logic [5:0] oe;
  } lcdp_first_drive_t;

  typedef struct packed {
    logic [4:0] level;
    logic [4:0] oe;
  } lcdp_second_drive_t;

endpackage

// ==== lcdp_ports_sva.sv ====
`timescale 1ns/100ps
module lcdp_ports_sva #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic warm_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire lcdp_pkg::lcdp_periph_t periph,
  input wire lcdp_pkg::lcdp_first_drive_t first_pin_drive,
  input wire lcdp_pkg::lcdp_second_drive_t second_pin_drive,
  input wire logic [7:0] lcd_segment_pin_select,
  input wire logic [31:0] seg_owned,
  input wire logic [3:0] com_owned
);
  import lcdp_pkg::*;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Bus
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_unmapped_a: assert property (pready && paddr == '0 |-> pslverr)
    else $error("no error on unmapped");
  first_upper_a: assert property (pready && !pwrite && paddr == 'h1c |-> prdata[31:6] == '0)
    else $error("upper data bits set");

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  lcd_owns_a: assert property ((second_pin_drive.oe & seg_owned[4:0]) == '0)
    else $error("lcd pin driven");
  com_or_seg_a: assert property (!(seg_owned[29] && com_owned[3]))
    else $error("pin both segment and common");
  power_on_lcd_a: assert property ($rose(presetn) |=> seg_owned[11:0] == 12'hfff)
    else $error("segments not owned after reset");
  timer_forces_a: assert property (periph.timer1_osc_en [*2] |-> first_pin_drive.oe[1:0] == 2'b00)
    else $error("oscillator pins driven");
  warm_dir_a: assert property ((warm_reset && periph == '0) [*2] |=> first_pin_drive.oe == '0)
    else $error("pins driven after reset");
  select_warm_a: assert property (warm_reset |=> ##1 lcd_segment_pin_select == 8'hff)
    else $error("select not reset");

  cover property (pready && pslverr);
  cover property (warm_reset);
  cover property (com_owned[3]);
endmodule

bind lcdp_ports lcdp_ports_sva #(.ADDR_WIDTH(ADDR_WIDTH)) i_lcdp_ports_sva (
  .pclk, .presetn, .warm_reset, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .periph, .first_pin_drive, .second_pin_drive, .lcd_segment_pin_select,
  .seg_owned, .com_owned
);

// ==== lcdp_board.sv ====
`timescale 1ns/100ps
module lcdp_board (
  input wire lcdp_pkg::lcdp_first_drive_t first_pin_drive,
  input wire lcdp_pkg::lcdp_second_drive_t second_pin_drive,
  input wire logic [5:0] ext_first,
  input wire logic [7:0] ext_second,
  input wire logic [7:0] ext_third,
  output logic [5:0] first_pin_in,
  output logic [7:0] second_pin_in,
  output logic [7:0] third_pin_in
);
  import lcdp_pkg::*;
  // Driven pins show the chip, released ones the board level
  assign first_pin_in = (first_pin_drive.oe & first_pin_drive.level)
    | (~first_pin_drive.oe & ext_first);
  assign second_pin_in[4:0] = (second_pin_drive.oe & second_pin_drive.level)
    | (~second_pin_drive.oe & ext_second[4:0]);
  assign second_pin_in[7:5] = ext_second[7:5];
  assign third_pin_in = ext_third;
endmodule

// ==== tb_lcdp_ports.sv ====
`timescale 1ns/100ps
module tb_lcdp_ports;
  import lcdp_pkg::*;
  logic pclk, presetn, warm_reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seg_owned;
  logic [3:0] pstrb, com_used, com_owned;
  lcdp_periph_t periph;
  lcdp_first_drive_t first_pin_drive;
  lcdp_second_drive_t second_pin_drive;
  logic [5:0] first_pin_in, first_pin_level, ext_first;
  logic [7:0] second_pin_in, second_pin_level, third_pin_in, third_pin_level;
  logic [7:0] ext_second, ext_third, lcd_segment_pin_select;
  int failures, tests_run;

  lcdp_ports i_lcdp_ports (.pclk, .presetn, .warm_reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .periph, .com_used, .first_pin_in,
    .first_pin_drive, .first_pin_level, .second_pin_in, .second_pin_drive,
    .second_pin_level, .third_pin_in, .third_pin_level, .lcd_segment_pin_select,
    .seg_owned, .com_owned);
  lcdp_board i_lcdp_board (.first_pin_drive, .second_pin_drive, .ext_first, .ext_second,
    .ext_third, .first_pin_in, .second_pin_in, .third_pin_in);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [8:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    logic [8:0] ri [4];
    logic [7:0] re [4];
    ri = '{IDX_FIRST_DIR, IDX_SECOND_DIR, IDX_THIRD_DIR, IDX_LCD_SEL};
    re = '{8'h3f, 8'hff, 8'hff, 8'hff};
    chk("seg owned", seg_owned, 32'he8000fff);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ri[i], 8'h00);
      chk("reset value", rd, 32'(re[i]));
    end
    chk("first oe", 32'(first_pin_drive.oe), 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_first();
    apb(1'b1, IDX_FIRST_DATA, 8'hea);
    apb(1'b1, IDX_FIRST_DIR, 8'h15);
    repeat (3) @(posedge pclk);
    chk("first oe", 32'(first_pin_drive.oe), 32'h2a);
    chk("first level", 32'(first_pin_drive.level & 6'h2a), 32'h2a);
    apb(1'b0, IDX_FIRST_DATA, 8'h00);
    chk("first pins", rd, 32'h2b);
    chk("first level", 32'(first_pin_level), 32'h2b);
    $display("t_first done");
  endtask

  task automatic t_periph();
    periph.timer1_osc_en <= 1'b1;
    apb(1'b1, IDX_FIRST_DIR, 8'h00);
    repeat (2) @(posedge pclk);
    chk("timer oe", 32'(first_pin_drive.oe), 32'h3c);
    periph <= '0;
    apb(1'b1, IDX_FIRST_DIR, 8'h3f);
    periph <= 10'h1e1;
    repeat (3) @(posedge pclk);
    chk("spi oe", 32'(first_pin_drive.oe), 32'h24);
    chk("spi level", 32'(first_pin_drive.level & 6'h24), 32'h24);
    periph <= 10'h132;
    repeat (3) @(posedge pclk);
    chk("i2c oe", 32'(first_pin_drive.oe), 32'h10);
    chk("i2c level", 32'(first_pin_drive.level[4]), 32'h0);
    periph <= '0;
    $display("t_periph done");
  endtask

  task automatic t_second();
    com_used <= 4'he;
    repeat (3) @(posedge pclk);
    chk("commons", 32'(com_owned), 32'he);
    chk("segments", seg_owned, 32'h08000fff);
    com_used <= 4'h0;
    apb(1'b1, IDX_LCD_SEL, 8'h00);
    apb(1'b1, IDX_SECOND_DIR, 8'he0);
    apb(1'b1, IDX_SECOND_DATA, 8'h13);
    repeat (3) @(posedge pclk);
    chk("no segments", seg_owned, 32'h0);
    chk("second oe", 32'(second_pin_drive.oe), 32'h1f);
    apb(1'b0, IDX_SECOND_DATA, 8'h00);
    chk("second pins", rd, 32'h53);
    chk("second level", 32'(second_pin_level), 32'h53);
    apb(1'b1, IDX_LCD_SEL, 8'h01);
    repeat (2) @(posedge pclk);
    chk("lcd low oe", 32'(second_pin_drive.oe), 32'h0);
    chk("lcd low seg", seg_owned, 32'h1f);
    $display("t_second done");
  endtask

  task automatic t_third();
    logic [7:0] sv [3];
    logic [31:0] se [3];
    sv = '{8'h02, 8'h04, 8'h40};
    se = '{32'h1e0, 32'he00, 32'h08000000};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, IDX_LCD_SEL, sv[i]);
      repeat (2) @(posedge pclk);
      chk("third seg", seg_owned, se[i]);
    end
    apb(1'b1, IDX_THIRD_DIR, 8'h00);
    apb(1'b1, IDX_THIRD_DATA, 8'hff);
    ext_third <= 8'h3c;
    repeat (3) @(posedge pclk);
    apb(1'b0, IDX_THIRD_DATA, 8'h00);
    chk("third pins", rd, 32'h3c);
    chk("third level", 32'(third_pin_level), 32'h3c);
    $display("t_third done");
  endtask

  task automatic t_warm();
    apb(1'b0, 9'h000, 8'h00);
    chk("unmapped", 32'(err), 32'h1);
    apb(1'b1, IDX_FIRST_DATA, 8'h15);
    apb(1'b1, IDX_SECOND_DATA, 8'h1f);
    warm_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    warm_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("warm oe", 32'(first_pin_drive.oe), 32'h0);
    chk("warm select", 32'(lcd_segment_pin_select), 32'hff);
    apb(1'b1, IDX_FIRST_DIR, 8'h00);
    apb(1'b1, IDX_LCD_SEL, 8'h00);
    apb(1'b1, IDX_SECOND_DIR, 8'h00);
    repeat (3) @(posedge pclk);
    apb(1'b0, IDX_FIRST_DATA, 8'h00);
    chk("kept latch", rd, 32'h15);
    chk("second level", 32'(second_pin_drive.level), 32'h0);
    $display("t_warm done");
  endtask

  initial
  begin
    failures = 0;
    tests_run = 0;
    presetn = 1'b0;
    warm_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    periph = '0;
    com_used = 4'h0;
    ext_first = 6'h21;
    ext_second = 8'h5a;
    ext_third = 8'ha5;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_first();
    t_periph();
    t_second();
    t_third();
    t_warm();
    final_report();
  end
endmodule
